// File: vsr_pkg.sv
// Shared constants and types for the velocity stop reaction block.
// Assumes one 250 MHz clock and an object access port driven by the fieldbus logic.
package vsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Object indexes and subindexes.
  localparam logic [15:0] VSR_IDX_STOP_RAMP  = 16'h604a;
  localparam logic [15:0] VSR_IDX_SPEED_UNIT = 16'h604c;
  localparam logic [15:0] VSR_IDX_QS_ACTION  = 16'h605a;
  localparam logic [15:0] VSR_IDX_SD_ACTION  = 16'h605b;
  localparam logic [7:0]  VSR_SUB_COUNT      = 8'h00;
  localparam logic [7:0]  VSR_SUB_FIRST      = 8'h01;
  localparam logic [7:0]  VSR_SUB_SECOND     = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [15:0] VSR_RST_QS_ACTION  = 16'h0002;
  localparam logic [15:0] VSR_RST_SD_ACTION  = 16'h0001;
  localparam logic [7:0]  VSR_ENTRY_COUNT    = 8'h02;
  localparam logic [31:0] VSR_RST_STOP_SPEED = 32'h00001388;
  localparam logic [15:0] VSR_RST_STOP_TIME  = 16'h0001;
  localparam logic [31:0] VSR_RST_UNIT_MUL   = 32'h00000001;
  localparam logic [31:0] VSR_RST_UNIT_DIV   = 32'h00000001;

  ////////////////////////////////////////////////////////////////////////////
  // Action codes.
  localparam logic [15:0] VSR_QS_IMMEDIATE  = 16'h0000;
  localparam logic [15:0] VSR_QS_SLOW_OFF   = 16'h0001;
  localparam logic [15:0] VSR_QS_QUICK_OFF  = 16'h0002;
  localparam logic [15:0] VSR_QS_SLOW_HOLD  = 16'h0005;
  localparam logic [15:0] VSR_QS_QUICK_HOLD = 16'h0006;
  localparam logic [15:0] VSR_SD_FREE       = 16'h0000;
  localparam logic [15:0] VSR_SD_SLOW       = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    VSR_SWITCH_ON_DISABLED,
    VSR_READY,
    VSR_OP_ENABLED,
    VSR_QS_BRAKE,
    VSR_QS_ACTIVE,
    VSR_SD_BRAKE
  } vsr_power_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } vsr_od_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } vsr_od_rsp_type;

  typedef struct packed {
    logic [31:0] speed_change;
    logic [15:0] time_change;
  } vsr_ramp_type;

  typedef struct packed {
    vsr_power_type      power;
    logic [15:0]        qs_action;
    logic [15:0]        sd_action;
    vsr_ramp_type       stop_ramp;
    logic [31:0]        unit_mul;
    logic [31:0]        unit_div;
    logic signed [31:0] speed;
    logic [15:0]        tick_cnt;
    logic               brake_quick;
    logic               brake_hold;
    vsr_od_rsp_type     rsp;
  } vsr_state_type;

  typedef struct packed {
    logic signed [63:0] product;
    logic signed [31:0] divisor;
    logic signed [31:0] rpm;
  } vsr_scale_state_type;

endpackage : vsr_pkg

// File: vsr_speed_scaler.sv
// Converts an internal speed into revolutions per minute by a multiplier and a divisor.
// Assumes speed, multiplier and divisor come from logic on the same clock.
`timescale 1ns/100ps

module vsr_speed_scaler
  import vsr_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic signed [31:0] speed_i,
  input  wire logic signed [31:0] mul_i,
  input  wire logic signed [31:0] div_i,
  output logic signed [31:0]      rpm_o
);

  vsr_scale_state_type cur;
  vsr_scale_state_type next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // Multiply in the first stage, divide in the second; a zero divisor holds the last result.
  always_comb
  begin
    next_cur         = cur;
    next_cur.product = 64'(speed_i) * 64'(mul_i);
    next_cur.divisor = div_i;
    if (cur.divisor != 32'sh0)
    begin
      next_cur.rpm = 32'(cur.product / 64'(cur.divisor));
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign rpm_o = cur.rpm;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_rpm_scale_math: assert property (
    ($past(div_i) != 32'sh0) |=> rpm_o == 32'(($past(speed_i, 2) * 64'($past(mul_i, 2))) / 64'($past(div_i, 2))))
    else $error("Scaled speed does not match multiplier and divisor.");

endmodule : vsr_speed_scaler

// File: vsr_stop_ctrl.sv
// Velocity stop reaction: stop ramp and speed unit objects, action selectors, stop sequencer.
// Assumes power commands, target speed and ramp ticks come from logic on the same clock.
`timescale 1ns/100ps

// How it works
// - Quick stop codes 2 and 6 in velocity mode brake with the velocity stop ramp object.
// - Stop ramp is speed change applied once per time change ticks.
// - Speed unit scaling sets the unit of velocity mode speeds.
// - Rpm equals internal speed times multiplier divided by divisor.
// - Quick stop code 0 stops at once, then switch-on-disabled.
// - Codes 1 and 2 brake on slow or quick ramp, then switch-on-disabled.
// - Codes 5 and 6 brake, then quick-stop-active with motor still energized.
// - From quick-stop-active after code 5 or 6, enable returns to operation.
// - Shutdown code 0 blocks the drive at once; motor turns freely.
// - Shutdown code 1 brakes on slow ramp, then ready-to-switch-on.
module vsr_stop_ctrl
  import vsr_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire vsr_od_req_type     od_req_i,
  output vsr_od_rsp_type          od_rsp_o,
  input  wire logic               velocity_mode_i,
  input  wire logic               qs_request_i,
  input  wire logic               shutdown_request_i,
  input  wire logic               enable_op_request_i,
  input  wire logic               ramp_tick_i,
  input  wire logic signed [31:0] target_speed_i,
  input  wire vsr_ramp_type       slow_ramp_i,
  input  wire vsr_ramp_type       general_stop_ramp_i,
  output logic signed [31:0]      speed_demand_o,
  output logic signed [31:0]      speed_rpm_o,
  output vsr_power_type           power_state_o,
  output logic                    drive_energized_o
);

  vsr_state_type cur;
  vsr_state_type next_cur;
  vsr_ramp_type  ramp_sel;
  logic [15:0]   ramp_time;
  logic          braking;
  logic          tick_due;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Moves a speed toward zero by one step without overshooting.
  function automatic logic signed [31:0] vsr_toward_zero(input logic signed [31:0] s, input logic [31:0] step);
    logic signed [32:0] mag;
    logic signed [32:0] stp;
    mag = (s < 32'sh0) ? -33'(s) : 33'(s);
    stp = $signed({1'b0, step});
    if (mag <= stp)
    begin
      return 32'sh0;
    end
    return (s < 32'sh0) ? s + $signed(step) : s - $signed(step);
  endfunction : vsr_toward_zero

  // Quick stop codes that the selector accepts.
  function automatic logic vsr_qs_code_ok(input logic [15:0] code);
    return (code == VSR_QS_IMMEDIATE) || (code == VSR_QS_SLOW_OFF) || (code == VSR_QS_QUICK_OFF)
        || (code == VSR_QS_SLOW_HOLD) || (code == VSR_QS_QUICK_HOLD);
  endfunction : vsr_qs_code_ok

  ////////////////////////////////////////////////////////////////////////////
  // Ramp selection and tick pacing.

  always_comb
  begin
    if (!cur.brake_quick)
    begin
      ramp_sel = slow_ramp_i;
    end
    else if (velocity_mode_i)
    begin
      ramp_sel = cur.stop_ramp;
    end
    else
    begin
      ramp_sel = general_stop_ramp_i;
    end
  end

  assign ramp_time = (ramp_sel.time_change == 16'h0000) ? 16'h0001 : ramp_sel.time_change;
  assign braking   = (cur.power == VSR_QS_BRAKE) || (cur.power == VSR_SD_BRAKE);
  assign tick_due  = ramp_tick_i && ((cur.tick_cnt + 16'h0001) >= ramp_time);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: object access, then the stop sequencer.
  always_comb
  begin
    next_cur           = cur;
    next_cur.rsp.ack   = od_req_i.valid;
    next_cur.rsp.err   = 1'b0;
    next_cur.rsp.rdata = 32'h00000000;
    if (od_req_i.valid)
    begin
      case (od_req_i.index)
        VSR_IDX_STOP_RAMP:
        begin
          next_cur.rsp.err = od_req_i.write && (od_req_i.subindex == VSR_SUB_COUNT);
          case (od_req_i.subindex)
            VSR_SUB_COUNT:  next_cur.rsp.rdata = 32'(VSR_ENTRY_COUNT);
            VSR_SUB_FIRST:
            begin
              next_cur.rsp.rdata = cur.stop_ramp.speed_change;
              if (od_req_i.write) next_cur.stop_ramp.speed_change = od_req_i.wdata;
            end
            VSR_SUB_SECOND:
            begin
              next_cur.rsp.rdata = 32'(cur.stop_ramp.time_change);
              if (od_req_i.write) next_cur.stop_ramp.time_change = od_req_i.wdata[15:0];
            end
            default:        next_cur.rsp.err = 1'b1;
          endcase
        end
        VSR_IDX_SPEED_UNIT:
        begin
          next_cur.rsp.err = od_req_i.write && (od_req_i.subindex == VSR_SUB_COUNT);
          case (od_req_i.subindex)
            VSR_SUB_COUNT:  next_cur.rsp.rdata = 32'(VSR_ENTRY_COUNT);
            VSR_SUB_FIRST:
            begin
              next_cur.rsp.rdata = cur.unit_mul;
              if (od_req_i.write) next_cur.unit_mul = od_req_i.wdata;
            end
            VSR_SUB_SECOND:
            begin
              next_cur.rsp.rdata = cur.unit_div;
              if (od_req_i.write) next_cur.unit_div = od_req_i.wdata;
            end
            default:        next_cur.rsp.err = 1'b1;
          endcase
        end
        VSR_IDX_QS_ACTION:
        begin
          next_cur.rsp.rdata = {{16{cur.qs_action[15]}}, cur.qs_action};
          if (od_req_i.subindex != VSR_SUB_COUNT)
          begin
            next_cur.rsp.err = 1'b1;
          end
          else if (od_req_i.write && !vsr_qs_code_ok(od_req_i.wdata[15:0]))
          begin
            next_cur.rsp.err = 1'b1;
          end
          else if (od_req_i.write)
          begin
            next_cur.qs_action = od_req_i.wdata[15:0];
          end
        end
        VSR_IDX_SD_ACTION:
        begin
          next_cur.rsp.rdata = {{16{cur.sd_action[15]}}, cur.sd_action};
          if (od_req_i.subindex != VSR_SUB_COUNT)
          begin
            next_cur.rsp.err = 1'b1;
          end
          else if (od_req_i.write && (od_req_i.wdata[15:0] != VSR_SD_FREE) && (od_req_i.wdata[15:0] != VSR_SD_SLOW))
          begin
            next_cur.rsp.err = 1'b1;
          end
          else if (od_req_i.write)
          begin
            next_cur.sd_action = od_req_i.wdata[15:0];
          end
        end
        default: next_cur.rsp.err = 1'b1;
      endcase
    end

    if (braking && ramp_tick_i)
    begin
      next_cur.tick_cnt = tick_due ? 16'h0000 : cur.tick_cnt + 16'h0001;
      if (tick_due)
      begin
        next_cur.speed = vsr_toward_zero(cur.speed, ramp_sel.speed_change);
      end
    end

    case (cur.power)
      VSR_OP_ENABLED:
      begin
        next_cur.speed    = target_speed_i;
        next_cur.tick_cnt = 16'h0000;
        if (qs_request_i)
        begin
          next_cur.brake_quick = (cur.qs_action == VSR_QS_QUICK_OFF) || (cur.qs_action == VSR_QS_QUICK_HOLD);
          next_cur.brake_hold  = (cur.qs_action == VSR_QS_SLOW_HOLD) || (cur.qs_action == VSR_QS_QUICK_HOLD);
          if (cur.qs_action == VSR_QS_IMMEDIATE)
          begin
            next_cur.speed = 32'sh0;
            next_cur.power = VSR_SWITCH_ON_DISABLED;
          end
          else
          begin
            next_cur.power = VSR_QS_BRAKE;
          end
        end
        else if (shutdown_request_i)
        begin
          next_cur.brake_quick = 1'b0;
          next_cur.brake_hold  = 1'b0;
          if (cur.sd_action == VSR_SD_FREE)
          begin
            next_cur.speed = 32'sh0;
            next_cur.power = VSR_READY;
          end
          else
          begin
            next_cur.power = VSR_SD_BRAKE;
          end
        end
      end
      // brake then disable; brake then hold.
      VSR_QS_BRAKE:
      begin
        if (cur.speed == 32'sh0)
        begin
          next_cur.power = cur.brake_hold ? VSR_QS_ACTIVE : VSR_SWITCH_ON_DISABLED;
        end
      end
      VSR_SD_BRAKE:
      begin
        if (cur.speed == 32'sh0)
        begin
          next_cur.power = VSR_READY;
        end
      end
      VSR_QS_ACTIVE:
      begin
        next_cur.speed = 32'sh0;
        if (enable_op_request_i)
        begin
          next_cur.power = VSR_OP_ENABLED;
        end
      end
      VSR_SWITCH_ON_DISABLED, VSR_READY:
      begin
        next_cur.speed = 32'sh0;
        if (enable_op_request_i)
        begin
          next_cur.power = VSR_OP_ENABLED;
        end
      end
      default: next_cur.power = VSR_SWITCH_ON_DISABLED;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cur                        <= '0;
      cur.power                  <= VSR_SWITCH_ON_DISABLED;
      cur.qs_action              <= VSR_RST_QS_ACTION;
      cur.sd_action              <= VSR_RST_SD_ACTION;
      cur.stop_ramp.speed_change <= VSR_RST_STOP_SPEED;
      cur.stop_ramp.time_change  <= VSR_RST_STOP_TIME;
      cur.unit_mul               <= VSR_RST_UNIT_MUL;
      cur.unit_div               <= VSR_RST_UNIT_DIV;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and speed unit conversion.
  assign od_rsp_o          = cur.rsp;
  assign speed_demand_o    = cur.speed;
  assign power_state_o     = cur.power;
  assign drive_energized_o = (cur.power == VSR_OP_ENABLED) || braking || (cur.power == VSR_QS_ACTIVE);

  vsr_speed_scaler u_scaler (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .speed_i   (cur.speed),
    .mul_i     ($signed(cur.unit_mul)),
    .div_i     ($signed(cur.unit_div)),
    .rpm_o     (speed_rpm_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_qs_hold_entry;
    (cur.power == VSR_OP_ENABLED) && qs_request_i
      && ((cur.qs_action == VSR_QS_SLOW_HOLD) || (cur.qs_action == VSR_QS_QUICK_HOLD));
  endsequence

  sequence s_brake_done_hold;
    (cur.power == VSR_QS_BRAKE) && (cur.speed == 32'sh0) && cur.brake_hold;
  endsequence

  chk_qs_ramp_select: assert property (
    ((cur.power == VSR_QS_BRAKE) && cur.brake_quick && velocity_mode_i && tick_due
      && !cur.stop_ramp.speed_change[31] && (cur.speed > $signed(cur.stop_ramp.speed_change)))
      |=> speed_demand_o == $past(cur.speed) - $signed($past(cur.stop_ramp.speed_change)))
    else $error("Velocity quick stop does not use the velocity stop ramp.");

  chk_ramp_pacing: assert property (
    (braking && !tick_due) |=> speed_demand_o == $past(speed_demand_o))
    else $error("Speed changed between ramp steps.");

  chk_immediate_stop: assert property (
    ((cur.power == VSR_OP_ENABLED) && qs_request_i && (cur.qs_action == VSR_QS_IMMEDIATE))
      |=> (power_state_o == VSR_SWITCH_ON_DISABLED) && (speed_demand_o == 32'sh0) && !drive_energized_o)
    else $error("Immediate stop did not zero speed and disable.");

  chk_brake_then_off: assert property (
    ((cur.power == VSR_QS_BRAKE) && (cur.speed == 32'sh0) && !cur.brake_hold)
      |=> power_state_o == VSR_SWITCH_ON_DISABLED)
    else $error("Braking quick stop did not end in switch on disabled.");

  chk_hold_entry: assert property (
    s_qs_hold_entry |=> (power_state_o == VSR_QS_BRAKE) && cur.brake_hold && drive_energized_o)
    else $error("Holding quick stop did not start braking with energy kept.");

  chk_hold_energized: assert property (
    s_brake_done_hold |=> (power_state_o == VSR_QS_ACTIVE) && drive_energized_o)
    else $error("Holding quick stop lost energy or state.");

  chk_return_to_op: assert property (
    ((cur.power == VSR_QS_ACTIVE) && enable_op_request_i) |=> power_state_o == VSR_OP_ENABLED)
    else $error("Quick stop active did not return to operation.");

  chk_free_turning: assert property (
    ((cur.power == VSR_OP_ENABLED) && shutdown_request_i && !qs_request_i && (cur.sd_action == VSR_SD_FREE))
      |=> (power_state_o == VSR_READY) && !drive_energized_o)
    else $error("Shutdown code zero did not block the drive.");

  chk_slow_shutdown: assert property (
    ((cur.power == VSR_OP_ENABLED) && shutdown_request_i && !qs_request_i && (cur.sd_action == VSR_SD_SLOW))
      |=> (power_state_o == VSR_SD_BRAKE) && !cur.brake_quick)
    else $error("Shutdown code one did not brake on the slow ramp.");

  chk_bad_code_kept: assert property (
    (od_req_i.valid && od_req_i.write && (od_req_i.index == VSR_IDX_QS_ACTION)
      && (od_req_i.subindex == VSR_SUB_COUNT) && !vsr_qs_code_ok(od_req_i.wdata[15:0]))
      |=> od_rsp_o.err && $stable(cur.qs_action))
    else $error("Undefined quick stop code was applied.");

endmodule : vsr_stop_ctrl

// File: vsr_tick_model.sv
// Ramp time base seen by the stop controller: one tick every gap_i plus one cycles.
// Assumes it shares the controller's clock and reset.
`timescale 1ns/100ps

module vsr_tick_model
  import vsr_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic [3:0] gap_i,
  output logic            tick_o
);
  logic [3:0] cnt;

  // A gap of zero ticks every cycle; a larger gap plays a slow time base.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt    <= 4'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= run_i && cnt >= gap_i;
      cnt    <= (run_i && cnt < gap_i) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : vsr_tick_model

// File: vsr_stop_ctrl_tb.sv
// Self-checking bench for the velocity stop reaction controller.
// Assumes vsr_pkg, the controller and vsr_tick_model are compiled first.
`timescale 1ns/100ps

module vsr_stop_ctrl_tb
  import vsr_pkg::*;
;
  typedef struct packed {logic chk; vsr_od_rsp_type r;} vsr_exp_type;

  localparam logic [15:0] RI [8] = '{16'h605a, 16'h605b, 16'h604a, 16'h604a, 16'h604a, 16'h604c, 16'h604c, 16'h604c};
  localparam logic [7:0]  RS [8] = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h2, 8'h0, 8'h1, 8'h2};
  localparam logic [31:0] RV [8] = '{32'h2, 32'h1, 32'h2, 32'h1388, 32'h1, 32'h2, 32'h1, 32'h1};
  localparam logic [15:0] FI [11] = '{16'h605a, 16'h605a, 16'h605a, 16'h605a, 16'h605b, 16'h605b,
                                      16'h604a, 16'h604c, 16'h605a, 16'h6046, 16'h604c};
  localparam logic [7:0]  FS [11] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h3};
  localparam logic [15:0] FW [11] = '{16'h3, 16'h4, 16'h7, 16'hffff, 16'h2, 16'hffff, 16'h5, 16'h5, 16'h6, 16'h1, 16'h1};
  localparam int          SK [8] = '{0, 0, 0, 0, 0, 2, 1, 1};
  localparam logic [15:0] SC [8] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6, 16'h6, 16'h0, 16'h1};
  localparam logic        SV [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  localparam int          SS [8] = '{0, 5, 4, 5, 4, 3, 0, 5};

  logic               clk;
  logic               rst_n;
  vsr_od_req_type     req;
  vsr_od_rsp_type     rsp;
  logic               vmode, qs_req, sd_req, en_req, tick, run, energized;
  logic [3:0]         gap;
  logic [31:0]        div;
  logic signed [31:0] target, speed, rpm, last_spd, e_val;
  vsr_ramp_type       slow_ramp, gen_ramp;
  vsr_power_type      power, brk, fin;
  logic [2:0]         last_pwr;
  vsr_exp_type        e_rsp;
  vsr_exp_type        rsp_q[$];
  logic [2:0]         pwr_q[$];
  logic signed [31:0] spd_q[$];
  int                 i, s, n_fail, num_checks;

  vsr_stop_ctrl dut_u (
    .ref_clk_i(clk), .reset_n_i(rst_n), .od_req_i(req), .od_rsp_o(rsp),
    .velocity_mode_i(vmode), .qs_request_i(qs_req), .shutdown_request_i(sd_req),
    .enable_op_request_i(en_req), .ramp_tick_i(tick), .target_speed_i(target),
    .slow_ramp_i(slow_ramp), .general_stop_ramp_i(gen_ramp), .speed_demand_o(speed),
    .speed_rpm_o(rpm), .power_state_o(power), .drive_energized_o(energized));

  vsr_tick_model tick_u (.ref_clk_i(clk), .reset_n_i(rst_n), .run_i(run), .gap_i(gap), .tick_o(tick));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  ////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_rsp(input vsr_exp_type e);
    num_checks++;
    if (rsp.err !== e.r.err || (e.chk && rsp.rdata !== e.r.rdata))
    begin
      n_fail++;
      $display("unexpected response at %0t: got %h expected %h", $time, rsp, e.r);
    end
  endtask : cmp_rsp

  // One object access; the answer is noted for the watcher.
  task automatic od(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                    input logic er, input logic ck, input logic [31:0] rd);
    @(posedge clk);
    #1;
    req = '{1'b1, w, idx, sub, wd};
    rsp_q.push_back({ck, 1'b1, er, rd});
    @(posedge clk);
    #1;
    req.valid = 1'b0;
  endtask : od

  // Holds power commands for one cycle.
  task automatic strobe(input logic q, input logic d, input logic e);
    @(posedge clk);
    #1;
    {qs_req, sd_req, en_req} = {q, d, e};
    @(posedge clk);
    #1;
    {qs_req, sd_req, en_req} = 3'b000;
  endtask : strobe

  // Waits, bounded, until every noted result has shown up.
  task automatic settle();
    int k = 0;
    while (rsp_q.size() + pwr_q.size() + spd_q.size() != 0 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 400)
    begin
      n_fail++;
      $display("unexpected stall at %0t: pending %h expected %h", $time, pwr_q.size() + spd_q.size(), 0);
      rsp_q.delete();
      pwr_q.delete();
      spd_q.delete();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////
  // Watcher: takes the oldest note whenever an answer, a state or a speed appears.
  always @(negedge clk)
  begin
    if (!rst_n)
    begin
      last_pwr = VSR_SWITCH_ON_DISABLED;
      last_spd = 32'sh0;
    end
    else
    begin
      if (rsp.ack === 1'b1)
      begin
        e_rsp = 'x;
        if (rsp_q.size() != 0)
          e_rsp = rsp_q.pop_front();
        cmp_rsp(e_rsp);
      end
      if (power !== last_pwr)
      begin
        e_val = 'x;
        if (pwr_q.size() != 0)
          e_val = {29'h0, pwr_q.pop_front()};
        cmp_val({29'h0, power}, e_val);
        last_pwr = power;
      end
      if (speed !== last_spd)
      begin
        e_val = 'x;
        if (spd_q.size() != 0)
          e_val = spd_q.pop_front();
        cmp_val(speed, e_val);
        last_spd = speed;
      end
    end
  end

  // Watchdog: the tests need far less than this span.
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    {vmode, qs_req, sd_req, en_req, run} = 5'b10000;
    gap = 4'h0;
    div = 32'h1;
    target = 32'sh0;
    slow_ramp = '{32'h5, 16'h1};
    gen_ramp = '{32'h3, 16'h1};
    n_fail = 0;
    num_checks = 0;
    void'($urandom(24805));
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    run = 1'b1;
    foreach (RI[j]) od(1'b0, RI[j], RS[j], 32'h0, 1'b0, 1'b1, RV[j]);
    foreach (FI[j]) od(1'b1, FI[j], FS[j], {16'h0, FW[j]}, 1'b1, 1'b0, 32'h0);
    foreach (RI[j]) od(1'b0, RI[j], RS[j], 32'h0, 1'b0, 1'b1, RV[j]);
    div = 32'(1 + $urandom % 7);
    od(1'b1, 16'h604a, 8'h1, 32'h4, 1'b0, 1'b1, 32'h1388);
    od(1'b1, 16'h604a, 8'h2, {16'($urandom), 16'h2}, 1'b0, 1'b1, 32'h1);
    od(1'b1, 16'h604c, 8'h1, 32'd60, 1'b0, 1'b1, 32'h1);
    od(1'b1, 16'h604c, 8'h2, div, 1'b0, 1'b1, 32'h1);
    od(1'b0, 16'h604a, 8'h2, 32'h0, 1'b0, 1'b1, 32'h2);
    od(1'b0, 16'h604c, 8'h2, 32'h0, 1'b0, 1'b1, div);
    settle();
    for (i = 0; i < 8; i++)
    begin
      vmode = SV[i];
      gap = 4'((i % 2) * 3);
      target = 32'(8 + $urandom % 33);
      brk = SK[i] == 1 ? VSR_SD_BRAKE : VSR_QS_BRAKE;
      fin = SK[i] == 1 ? VSR_READY : (SC[i] > 16'h2 ? VSR_QS_ACTIVE : VSR_SWITCH_ON_DISABLED);
      od(1'b1, SK[i] == 1 ? 16'h605b : 16'h605a, 8'h0, {16'($urandom), SC[i]}, 1'b0, 1'b0, 32'h0);
      pwr_q.push_back(VSR_OP_ENABLED);
      spd_q.push_back(target);
      strobe(1'b0, 1'b0, 1'b1);
      settle();
      cmp_val(rpm, 32'(target * 60 / div));
      cmp_val({31'h0, energized}, 32'h1);
      if (SS[i] != 0)
        pwr_q.push_back(brk);
      s = target;
      do
      begin
        s = (SS[i] == 0 || s <= SS[i]) ? 0 : s - SS[i];
        spd_q.push_back(s);
      end
      while (s != 0);
      pwr_q.push_back(fin);
      strobe(SK[i] != 1, SK[i] != 0, 1'b0);
      settle();
      cmp_val({31'h0, energized}, {31'h0, fin == VSR_QS_ACTIVE});
    end
    od(1'b1, 16'h605a, 8'h0, 32'h5, 1'b0, 1'b1, 32'h6);
    pwr_q.push_back(VSR_OP_ENABLED);
    spd_q.push_back(target);
    strobe(1'b0, 1'b0, 1'b1);
    settle();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    foreach (RI[j]) od(1'b0, RI[j], RS[j], 32'h0, 1'b0, 1'b1, RV[j]);
    settle();
    wrap_up();
  end
endmodule : vsr_stop_ctrl_tb
